// ==== hw/line_filter.sv ====
// module: line-state filter that holds off changes for 2**sel clocks
`timescale 1ns/10ps
module line_filter #(
  parameter int SEL_W = 4
) (
  // clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // raw line and delay selection
  input  wire logic [1:0]       line_raw,
  input  wire logic [SEL_W-1:0] delay_log2,
  // filtered line
  output logic      [1:0]       line_filt
);
  localparam int CW = (1 << SEL_W) + 1;
  logic [1:0]    cand_r;    // value being timed
  logic [CW-1:0] cnt_r;     // clocks the candidate has held
  logic [CW-1:0] limit;     // 2**delay_log2

  assign limit = CW'(1) << delay_log2;

  // time each change; propagate after it has held 2**n clocks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cand_r    <= 2'b10;
      cnt_r     <= '0;
      line_filt <= 2'b10;
    end else if (line_raw != cand_r) begin
      cand_r <= line_raw;     // restart on any new change
      cnt_r  <= CW'(1);
    end else if (cand_r != line_filt) begin
      if (cnt_r >= limit) begin
        line_filt <= cand_r;
      end else begin
        cnt_r <= cnt_r + CW'(1);
      end
    end
  end

  // the filtered line only moves once the candidate has held the programmed delay
  a_filter_delay: assert property (@(posedge pclk) disable iff (!presetn)
    (line_filt != $past(line_filt)) |-> ($past(cnt_r) >= $past(limit)))
    else $error("filtered line changed before delay");
endmodule // line_filter

// ==== hw/usb_phy_control_regs.sv ====
// module: apb slave for the usb transceiver control and power signalling registers
//
// The APB register port was left to the implementer.
`timescale 1ns/10ps
module usb_phy_control_regs
  import usb_phy_ctrl_pkg::*;
#(
  parameter int FILT_W = 4
) (
  // apb slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // transceiver line and suspend
  input  wire logic [1:0]  line_state,
  input  wire logic        suspended,
  // transceiver controls
  output logic [2:0]       transceiver_config_pins,
  output logic             port_eight_a_pd_dis,
  output logic             port_eight_b_pd_dis,
  output logic             hw_resume,
  // power signalling out
  output logic [7:0]       power_sig_data,
  output logic             power_sig_valid,
  // interrupt
  output logic             irq
);
  import usb_phy_ctrl_pkg::*;

  // ****************************************************************
  // bus decode
  // ****************************************************************
  logic        acc;         // access phase
  logic        wr;          // write takes effect
  logic        hit;         // mapped address
  logic [31:0] ctrl_r;      // transceiver control
  logic [31:0] psig_r;      // power signalling
  logic [2:0]  ista_r;      // interrupt status
  logic [2:0]  imsk_r;      // interrupt mask
  logic [1:0]  line_filt;   // filtered line
  logic [1:0]  filt_prev_r; // previous filtered line
  susp_e       st_r;        // suspend controller state
  logic        se0_evt;     // auto-resume by bus reset
  logic        k_evt;       // auto-resume by k
  logic        line_evt;    // filtered line change
  logic [31:0] rd_mux;      // read data

  assign acc = psel && penable;
  assign wr  = acc && pwrite;
  assign hit = (paddr == OFS_POWER_SIG) || (paddr == OFS_XCVR_CTRL) ||
               (paddr == OFS_IRQ_STATUS) || (paddr == OFS_IRQ_MASK) ||
               (paddr == OFS_LINE_STAT);

  // ****************************************************************
  // line filter
  // ****************************************************************
  line_filter #(.SEL_W(FILT_W)) u_filt (
    .pclk       (pclk),
    .presetn    (presetn),
    .line_raw   (line_state),
    .delay_log2 (ctrl_r[POS_FILT_LO +: FILT_W]),
    .line_filt  (line_filt)
  );

  // ****************************************************************
  // suspend controller
  // ****************************************************************
  // hardware resume: leaves suspend on se0 or k when enabled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= ST_ACTIVE;
    end else begin
      case (st_r)
        ST_ACTIVE:  if (suspended) st_r <= ST_SUSPEND;
        ST_SUSPEND: if (se0_evt || k_evt) st_r <= ST_RESUMED;
        ST_RESUMED: if (!suspended) st_r <= ST_ACTIVE;
        default:    st_r <= ST_ACTIVE;
      endcase
    end
  end

  assign se0_evt  = (st_r == ST_SUSPEND) && ctrl_r[POS_HW_RESUME] && (line_filt == LS_SE0);
  assign k_evt    = (st_r == ST_SUSPEND) && ctrl_r[POS_HW_RESUME] && (line_filt == LS_K);
  assign line_evt = (line_filt != filt_prev_r);

  // previous filtered line for software polling events
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) filt_prev_r <= 2'b10;
    else          filt_prev_r <= line_filt;
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  // transceiver control; hardware set of cause flags beats a clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= RST_XCVR_CTRL;
    end else begin
      if (wr && paddr == OFS_XCVR_CTRL) begin
        ctrl_r <= pwdata & MASK_XCVR_CTRL;
      end
      if (se0_evt) ctrl_r[POS_SE0_CAUSE] <= 1'b1;
      if (k_evt)   ctrl_r[POS_K_CAUSE]   <= 1'b1;
    end
  end

  // power signalling
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)                        psig_r <= RST_POWER_SIG;
    else if (wr && paddr == OFS_POWER_SIG) psig_r <= pwdata & MASK_POWER_SIG;
  end

  // interrupt status, write one to clear, set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ista_r <= 3'h0;
    end else begin
      ista_r <= (ista_r & ~((wr && paddr == OFS_IRQ_STATUS) ? pwdata[2:0] : 3'h0))
              | {line_evt, k_evt, se0_evt};
    end
  end

  // interrupt mask
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)                         imsk_r <= 3'h0;
    else if (wr && paddr == OFS_IRQ_MASK) imsk_r <= pwdata[2:0];
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (paddr)
      OFS_POWER_SIG:  rd_mux = psig_r;
      OFS_XCVR_CTRL:  rd_mux = ctrl_r;
      OFS_IRQ_STATUS: rd_mux = {29'h0, ista_r};
      OFS_IRQ_MASK:   rd_mux = {29'h0, imsk_r};
      OFS_LINE_STAT:  rd_mux = {28'h0, st_r, line_filt}; // resume polling
      default:        rd_mux = 32'h0000_0000;
    endcase
  end

  // zero-wait-state apb answer: ready in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !hit;
      prdata  <= (psel && !penable && !pwrite) ? rd_mux : 32'h0000_0000;
    end
  end

  // pins from registered control state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      transceiver_config_pins <= 3'h0;
      port_eight_a_pd_dis     <= 1'b0;
      port_eight_b_pd_dis     <= 1'b0;
      hw_resume               <= 1'b0;
      power_sig_data          <= 8'h00;
      power_sig_valid         <= 1'b0;
      irq                     <= 1'b0;
    end else begin
      transceiver_config_pins <= ctrl_r[POS_CONF_LO +: 3];
      port_eight_a_pd_dis     <= ctrl_r[POS_PD_DIS];
      port_eight_b_pd_dis     <= ctrl_r[POS_PD_DIS];
      hw_resume               <= ctrl_r[POS_HW_RESUME];
      power_sig_data          <= psig_r[7:0];
      power_sig_valid         <= psig_r[POS_PS_VALID];
      irq                     <= |(ista_r & imsk_r);
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  a_pulldown_follow: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 port_eight_a_pd_dis == $past(ctrl_r[POS_PD_DIS]))
    else $error("pulldown disable does not follow register");
  a_se0_cause_set: assert property (@(posedge pclk) disable iff (!presetn)
    se0_evt |=> ctrl_r[POS_SE0_CAUSE])
    else $error("se0 cause flag not set");
  a_k_cause_set: assert property (@(posedge pclk) disable iff (!presetn)
    k_evt |=> ctrl_r[POS_K_CAUSE])
    else $error("k cause flag not set");
  a_no_sw_resume: assert property (@(posedge pclk) disable iff (!presetn)
    !ctrl_r[POS_HW_RESUME] |-> !(se0_evt || k_evt))
    else $error("hardware resume while disabled");
  a_config_pins: assert property (@(posedge pclk) disable iff (!presetn)
    $changed(ctrl_r[6:4]) |=> transceiver_config_pins == $past(ctrl_r[6:4]))
    else $error("config pins lag register");
  a_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn)
    ((ctrl_r & ~MASK_XCVR_CTRL) == 32'h0) && ((psig_r & ~MASK_POWER_SIG) == 32'h0))
    else $error("reserved bit set");
  a_cause_sticky: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_r[POS_SE0_CAUSE] && !(wr && paddr == OFS_XCVR_CTRL) |=> ctrl_r[POS_SE0_CAUSE])
    else $error("se0 cause cleared without write");
  a_apb_ready: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable |=> pready ##1 !pready)
    else $error("pready timing wrong");
  c_se0_resume: cover property (@(posedge pclk) disable iff (!presetn) se0_evt);
  c_k_resume:   cover property (@(posedge pclk) disable iff (!presetn) k_evt);
  c_irq:        cover property (@(posedge pclk) disable iff (!presetn) $rose(irq));
endmodule // usb_phy_control_regs

// ==== pkg/usb_phy_ctrl_pkg.sv ====
// package: register map, field layout and reset values of the transceiver control registers
// ****************************************************************
// ****************************************************************
package usb_phy_ctrl_pkg;
  // register byte offsets
  localparam logic [7:0]  OFS_POWER_SIG  = 8'h3c;
  localparam logic [7:0]  OFS_XCVR_CTRL  = 8'h40;
  localparam logic [7:0]  OFS_IRQ_STATUS = 8'h44;
  localparam logic [7:0]  OFS_IRQ_MASK   = 8'h48;
  localparam logic [7:0]  OFS_LINE_STAT  = 8'h4c;
  // field positions in the transceiver control register
  localparam int          POS_PD_DIS     = 18;
  localparam int          POS_SE0_CAUSE  = 13;
  localparam int          POS_K_CAUSE    = 12;
  localparam int          POS_FILT_LO    = 8;
  localparam int          POS_HW_RESUME  = 7;
  localparam int          POS_CONF_LO    = 4;
  // power signalling register layout
  localparam int          POS_PS_VALID   = 8;
  // writable masks (everything else reserved)
  localparam logic [31:0] MASK_XCVR_CTRL = 32'h0004_3ff0;
  localparam logic [31:0] MASK_POWER_SIG = 32'h0000_01ff;
  // reset values
  localparam logic [31:0] RST_XCVR_CTRL  = 32'h0000_0000;
  localparam logic [31:0] RST_POWER_SIG  = 32'h0000_0000;
  // line state encodings (dp, dm)
  localparam logic [1:0]  LS_SE0         = 2'b00;
  localparam logic [1:0]  LS_J           = 2'b10;
  localparam logic [1:0]  LS_K           = 2'b01;
  // interrupt status bits
  localparam int          IRQ_SE0        = 0;
  localparam int          IRQ_K          = 1;
  localparam int          IRQ_LINE       = 2;
  // suspend controller states, gray along idle->suspended->resumed
  typedef enum logic [1:0] {
    ST_ACTIVE  = 2'b00,
    ST_SUSPEND = 2'b01,
    ST_RESUMED = 2'b11
  } susp_e;
endpackage

// ==== test/usb_line_model.sv ====
// file: behavioural model of the transceiver line state and suspend detector
`timescale 1ns/10ps
module usb_line_model (
  // clock
  input  wire logic       pclk,
  // bench requests
  input  wire logic [1:0] want_line,
  input  wire logic       want_susp,
  // towards the block
  output logic      [1:0] line_state,
  output logic            suspended
);
  // ****************************************************************
  // line driver
  // ****************************************************************
  // line and suspend follow the request one edge later, like a synchroniser
  always_ff @(posedge pclk) begin
    line_state <= want_line;
    suspended  <= want_susp;
  end
endmodule // usb_line_model

// ==== test/usb_phy_control_regs_tb.sv ====
// file: self-checking bench for the transceiver control register block
`timescale 1ns/10ps
module usb_phy_control_regs_tb;
  import usb_phy_ctrl_pkg::*;
  // ****************************************************************
  // signals
  // ****************************************************************
  logic        pclk = 1'b0;            // bus clock
  logic        presetn = 1'b0;         // reset, active low
  logic        psel = 1'b0;            // apb request
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [1:0]  want_line = LS_J;       // requested line level
  logic        want_susp = 1'b0;       // requested suspend level
  wire  [31:0] prdata;
  wire         pready, pslverr, hw_resume, power_sig_valid, irq, pd_a, pd_b, susp;
  wire  [2:0]  cfg_pins;
  wire  [7:0]  power_sig_data;
  wire  [1:0]  line;
  logic [31:0] rd;                     // last read data
  logic        er;                     // last error response
  int          failures = 0;
  int          checked = 0;
  always #5 pclk = ~pclk;
  // ****************************************************************
  // design and partner
  // ****************************************************************
  usb_phy_control_regs #(.FILT_W(4)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .line_state(line), .suspended(susp),
    .transceiver_config_pins(cfg_pins), .port_eight_a_pd_dis(pd_a),
    .port_eight_b_pd_dis(pd_b), .hw_resume(hw_resume), .power_sig_data(power_sig_data),
    .power_sig_valid(power_sig_valid), .irq(irq));
  usb_line_model u_line (.pclk(pclk), .want_line(want_line), .want_susp(want_susp),
    .line_state(line), .suspended(susp));
  // ****************************************************************
  // tasks
  // ****************************************************************
  // compare and count
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // counts and verdict
  task automatic test_done;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // one apb transfer, then an idle edge so requests never collide
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      failures++;
      $display("[ERR] %0t no pready", $time);
      test_done();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d); xfer(1'b1, a, d); endtask
  task automatic rdr(input logic [7:0] a); xfer(1'b0, a, 32'h0000_0000); endtask
  task automatic tick(input int n); repeat (n) @(posedge pclk); endtask
  // ****************************************************************
  // sequence
  // ****************************************************************
  initial begin
    tick(12);
    presetn <= 1'b1;
    // reset values
    rdr(OFS_XCVR_CTRL); check(rd, RST_XCVR_CTRL);
    rdr(OFS_POWER_SIG); check(rd, RST_POWER_SIG);
    check({27'h0, cfg_pins, pd_a, pd_b}, 32'h0000_0000);
    $display("reset test done");
    // all ones except the cause bits: reserved bits drop, fields reach the pins
    wr(OFS_XCVR_CTRL, 32'hffff_cfff); rdr(OFS_XCVR_CTRL); check(rd, 32'h0004_0ff0);
    @(negedge pclk);
    check({29'h0, cfg_pins}, 32'h0000_0007);
    check({30'h0, pd_a, pd_b}, 32'h0000_0003);
    check({31'h0, hw_resume}, 32'h0000_0001);
    wr(OFS_XCVR_CTRL, 32'h0000_0050); @(negedge pclk);
    check({28'h0, cfg_pins, hw_resume}, 32'h0000_000a);
    check({30'h0, pd_a, pd_b}, 32'h0000_0000);
    wr(OFS_POWER_SIG, 32'hffff_ff5a); rdr(OFS_POWER_SIG); check(rd, 32'h0000_015a);
    check({23'h0, power_sig_valid, power_sig_data}, 32'h0000_015a);
    wr(8'h00, 32'hffff_ffff); check({31'h0, er}, 32'h0000_0001);
    rdr(8'h00); check(rd, 32'h0000_0000);
    $display("field test done");
    // filter of sixteen clocks: old level early, new level late
    wr(OFS_XCVR_CTRL, 32'h0000_0400); want_line <= LS_K;
    tick(8); rdr(OFS_LINE_STAT); check({30'h0, rd[1:0]}, {30'h0, LS_J});
    tick(16); rdr(OFS_LINE_STAT); check({30'h0, rd[1:0]}, {30'h0, LS_K});
    $display("filter test done");
    // k resume while suspended, hardware handling on
    wr(OFS_XCVR_CTRL, 32'h0000_0080); want_line <= LS_J; tick(4);
    want_susp <= 1'b1; tick(4); want_line <= LS_K; tick(6);
    rdr(OFS_XCVR_CTRL); check(rd, 32'h0000_1080);
    rdr(OFS_IRQ_STATUS); check({31'h0, rd[IRQ_K]}, 32'h0000_0001);
    check({31'h0, irq}, 32'h0000_0000);
    wr(OFS_IRQ_MASK, 32'h0000_0002); @(negedge pclk); check({31'h0, irq}, 32'h0000_0001);
    wr(OFS_XCVR_CTRL, 32'h0000_0080); rdr(OFS_XCVR_CTRL); check(rd, 32'h0000_0080);
    wr(OFS_IRQ_STATUS, 32'h0000_0007); @(negedge pclk); check({31'h0, irq}, 32'h0000_0000);
    $display("k resume test done");
    // se0 resume after a fresh suspend, masked then unmasked
    // line back to idle j first, so a fresh suspend does not resume on the old k level
    want_susp <= 1'b0; want_line <= LS_J; tick(4);
    want_susp <= 1'b1; tick(4); want_line <= LS_SE0; tick(6);
    rdr(OFS_XCVR_CTRL); check(rd, 32'h0000_2080);
    @(negedge pclk); check({31'h0, irq}, 32'h0000_0000);
    wr(OFS_IRQ_MASK, 32'h0000_0001); @(negedge pclk); check({31'h0, irq}, 32'h0000_0001);
    wr(OFS_XCVR_CTRL, 32'h0000_0080); rdr(OFS_XCVR_CTRL); check(rd, 32'h0000_0080);
    $display("se0 resume test done");
    // software handling: no cause flag
    wr(OFS_XCVR_CTRL, 32'h0000_0000); want_line <= LS_J; want_susp <= 1'b0; tick(4);
    want_susp <= 1'b1; tick(4); want_line <= LS_K; tick(6);
    rdr(OFS_XCVR_CTRL); check(rd, 32'h0000_0000);
    $display("software resume test done");
    test_done();
  end
  // hang guard
  initial begin
    tick(20000);
    failures++;
    $display("[ERR] %0t run too long", $time);
    test_done();
  end
endmodule // usb_phy_control_regs_tb
